// [verilog/flyback_pkg.sv]
// Notes on behaviour
// - fixed average frequency discontinuous primary switching
// - dither switching period plus minus six percent
// - current sense trip ends the on-time
// - overvoltage above rise threshold stops primary switch drive
// - overvoltage releases only below fall threshold
// - soft start ramps compensation after primary reset
// - secondary below start level at ramp end: off
// - start-up timeout off until primary power cycle
// - normal operation leaves both flags released
// - undervoltage drives supply flag only
// - overvoltage drives supply flag only
// - short fault: soft shutdown, short flag low
// - secondary pulses feedback emitter above liveness level
// - no feedback pulses: drive and compensation low
// - feedback fault drives both flags until power cycle
// - secondary above rise threshold clears undervoltage
// - overvoltage leaves gate output and shutdown alone
// - short clears after mute plus emitter-low reset time
package flyback_pkg;

  localparam longint unsigned CLK_HZ          = 100_000_000;

  // primary switching
  localparam longint unsigned SW_FREQ_HZ      = 135_000;
  localparam int unsigned     SW_PERIOD_CYC   = int'(CLK_HZ / SW_FREQ_HZ);
  localparam int unsigned     DITHER_PCT      = 6;
  localparam int unsigned     DITHER_CYC      = (SW_PERIOD_CYC * DITHER_PCT) / 100;
  // caps the on-time at one half of the centre period for discontinuous conduction
  localparam int unsigned     ON_MAX_CYC      = SW_PERIOD_CYC / 2;

  // soft start
  localparam longint unsigned SOFT_START_MS   = 20;
  localparam int unsigned     SOFT_START_CYC  = int'((SOFT_START_MS * CLK_HZ) / 1000);
  localparam int unsigned     COMP_STEPS      = 256;

  // feedback liveness
  localparam longint unsigned FB_TIMEOUT_US   = 100;
  localparam int unsigned     FB_TIMEOUT_CYC  = int'((FB_TIMEOUT_US * CLK_HZ) / 1_000_000);
  localparam longint unsigned FB_PULSE_US     = 10;
  localparam int unsigned     FB_PULSE_CYC    = int'((FB_PULSE_US * CLK_HZ) / 1_000_000);

  // short-circuit fault timing
  localparam longint unsigned MUTE_TIME_NS    = 1000;
  localparam int unsigned     MUTE_CYC        = int'((MUTE_TIME_NS * CLK_HZ + 999_999_999) / 1_000_000_000);
  localparam longint unsigned RESET_TIME_NS   = 500;
  localparam int unsigned     RESET_CYC       = int'((RESET_TIME_NS * CLK_HZ + 999_999_999) / 1_000_000_000);

  // reset values
  localparam logic [7:0]      COMP_RST        = 8'h00;
  localparam logic [31:0]     CNT_RST         = 32'h0000_0000;

  typedef enum logic [1:0] {
    ST_SOFT_START = 2'b00,
    ST_RUN        = 2'b01,
    ST_TIMEOUT    = 2'b10,
    ST_FB_FAULT   = 2'b11
  } sup_state_t;

  typedef enum logic [1:0] {
    SC_IDLE  = 2'b00,
    SC_MUTE  = 2'b01,
    SC_WAIT  = 2'b10
  } sc_state_t;

endpackage

// [verilog/switching_timer.sv]
`timescale 1ns/1ps
module switching_timer #(
  parameter int unsigned PERIOD = flyback_pkg::SW_PERIOD_CYC,
  parameter int unsigned DITHER = flyback_pkg::DITHER_CYC
) (
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        sys_rst,
  // control
  input  wire logic        enable,
  input  wire logic [15:0] on_cycles,
  input  wire logic        current_trip,
  // drive
  output logic             drive
);

  logic [15:0] cnt_reg,    cnt_next;
  logic [15:0] dith_reg,   dith_next;
  logic        up_reg,     up_next;
  logic        drive_reg,  drive_next;
  logic [15:0] period_now;

  // the period walks a triangle so the average stays at the centre frequency
  assign period_now = 16'(PERIOD - DITHER) + dith_reg;

  always_comb begin
    cnt_next   = cnt_reg + 16'h0001;
    dith_next  = dith_reg;
    up_next    = up_reg;
    drive_next = drive_reg;
    if (cnt_reg >= period_now - 16'h0001) begin
      cnt_next = 16'h0000;
      if (up_reg) begin
        if (dith_reg >= 16'(2 * DITHER)) begin
          up_next   = 1'b0;
          dith_next = dith_reg - 16'h0001;
        end else begin
          dith_next = dith_reg + 16'h0001;
        end
      end else begin
        if (dith_reg == 16'h0000) begin
          up_next   = 1'b1;
          dith_next = 16'h0001;
        end else begin
          dith_next = dith_reg - 16'h0001;
        end
      end
    end
    if (cnt_reg == 16'h0000) begin
      drive_next = enable && (on_cycles != 16'h0000) && !current_trip;
    end else if (cnt_reg >= on_cycles) begin
      drive_next = 1'b0;
    end
    if (current_trip || !enable) begin
      drive_next = 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      cnt_reg   <= 16'h0000;
      dith_reg  <= 16'(DITHER);
      up_reg    <= 1'b1;
      drive_reg <= 1'b0;
    end else begin
      cnt_reg   <= cnt_next;
      dith_reg  <= dith_next;
      up_reg    <= up_next;
      drive_reg <= drive_next;
    end
  end

  assign drive = drive_reg;

endmodule // switching_timer

// [verilog/flyback_supervisor.sv]
`timescale 1ns/1ps
module flyback_supervisor #(
  parameter int unsigned SOFT_START_CYCLES = flyback_pkg::SOFT_START_CYC,
  parameter int unsigned FB_TIMEOUT_CYCLES = flyback_pkg::FB_TIMEOUT_CYC
) (
  // clock and reset (reset is the primary undervoltage lockout)
  input  wire logic        ref_clk,
  input  wire logic        sys_rst,
  // supply comparators
  input  wire logic        primary_supply_low,
  input  wire logic        secondary_below_uv_fall,
  input  wire logic        secondary_above_uv_rise,
  input  wire logic        secondary_above_ov_rise,
  input  wire logic        secondary_below_ov_fall,
  input  wire logic        secondary_above_startup,
  input  wire logic        secondary_above_liveness,
  // primary current sense
  input  wire logic        current_sense_trip,
  // feedback channel, as received on the primary side
  input  wire logic        feedback_pulse_in,
  // gate driver side
  input  wire logic        input_emitter,
  input  wire logic        short_circuit_detect,
  // primary switch and compensation node
  output logic             primary_switch_drive,
  output logic [7:0]       comp_level,
  output logic             comp_pull_low,
  // secondary outputs
  output logic             feedback_emitter,
  output logic             gate_output,
  output logic             gate_output_oe,
  output logic             soft_shutdown_output,
  output logic             soft_shutdown_oe,
  // open-drain status flags
  output logic             supply_fault_flag_n_o,
  output logic             supply_fault_flag_n_oe,
  output logic             short_fault_flag_n_o,
  output logic             short_fault_flag_n_oe
);

  localparam int unsigned STEP_CYC = SOFT_START_CYCLES / flyback_pkg::COMP_STEPS;

  flyback_pkg::sup_state_t state_reg, state_next;
  flyback_pkg::sc_state_t  sc_reg,    sc_next;
  logic [31:0] ss_cnt_reg,   ss_cnt_next;
  logic [31:0] step_cnt_reg, step_cnt_next;
  logic [7:0]  comp_reg,     comp_next;
  logic [31:0] wd_cnt_reg,   wd_cnt_next;
  logic        fb_prev_reg,  fb_prev_next;
  logic [31:0] tx_cnt_reg,   tx_cnt_next;
  logic        emit_reg,     emit_next;
  logic        uv2_reg,      uv2_next;
  logic        ov_reg,       ov_next;
  logic [31:0] sc_cnt_reg,   sc_cnt_next;
  logic        drive_reg,    drive_next;
  logic        gate_reg,     gate_next;
  logic        supply_oe_reg, supply_oe_next;
  logic        short_oe_reg,  short_oe_next;
  logic        pull_low_reg,  pull_low_next;
  logic        gate_oe_reg,   gate_oe_next;
  logic        shutdown_oe_reg, shutdown_oe_next;
  logic        gate_en;
  logic        timer_drive;
  logic [17:0] on_prod;
  logic [15:0] on_cycles;
  logic        supply_fault;
  logic        short_fault;

  // on-time scales with the compensation level, capped at half the centre period
  assign on_prod   = 18'(comp_reg) * 18'(flyback_pkg::ON_MAX_CYC);
  assign on_cycles = {6'h00, on_prod[17:8]};

  // overvoltage and start-up faults gate only the primary switch
  assign gate_en = (state_reg == flyback_pkg::ST_SOFT_START || state_reg == flyback_pkg::ST_RUN)
                   && !ov_reg;

  switching_timer #(
    .PERIOD (flyback_pkg::SW_PERIOD_CYC),
    .DITHER (flyback_pkg::DITHER_CYC)
  ) u_timer (
    .ref_clk      (ref_clk),
    .sys_rst      (sys_rst),
    .enable       (gate_en),
    .on_cycles    (on_cycles),
    .current_trip (current_sense_trip),
    .drive        (timer_drive)
  );

  // start-up sequencing and feedback watchdog
  always_comb begin
    state_next    = state_reg;
    ss_cnt_next   = ss_cnt_reg;
    step_cnt_next = step_cnt_reg;
    comp_next     = comp_reg;
    wd_cnt_next   = wd_cnt_reg;
    fb_prev_next  = feedback_pulse_in;
    case (state_reg)
      flyback_pkg::ST_SOFT_START: begin
        ss_cnt_next = ss_cnt_reg + 32'h0000_0001;
        if (step_cnt_reg >= 32'(STEP_CYC) - 32'h0000_0001) begin
          step_cnt_next = flyback_pkg::CNT_RST;
          if (comp_reg != 8'hff) begin
            comp_next = comp_reg + 8'h01;
          end
        end else begin
          step_cnt_next = step_cnt_reg + 32'h0000_0001;
        end
        if (ss_cnt_reg >= 32'(SOFT_START_CYCLES) - 32'h0000_0001) begin
          wd_cnt_next = flyback_pkg::CNT_RST;
          if (secondary_above_startup) begin
            state_next = flyback_pkg::ST_RUN;
          end else begin
            state_next = flyback_pkg::ST_TIMEOUT;
          end
        end
      end
      flyback_pkg::ST_RUN: begin
        if (feedback_pulse_in && !fb_prev_reg) begin
          wd_cnt_next = flyback_pkg::CNT_RST;
        end else if (wd_cnt_reg >= 32'(FB_TIMEOUT_CYCLES) - 32'h0000_0001) begin
          state_next = flyback_pkg::ST_FB_FAULT;
        end else begin
          wd_cnt_next = wd_cnt_reg + 32'h0000_0001;
        end
      end
      flyback_pkg::ST_TIMEOUT: begin
        state_next = flyback_pkg::ST_TIMEOUT;
      end
      flyback_pkg::ST_FB_FAULT: begin
        comp_next  = flyback_pkg::COMP_RST;
        state_next = flyback_pkg::ST_FB_FAULT;
      end
      default: state_next = flyback_pkg::ST_SOFT_START;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      state_reg    <= flyback_pkg::ST_SOFT_START;
      ss_cnt_reg   <= flyback_pkg::CNT_RST;
      step_cnt_reg <= flyback_pkg::CNT_RST;
      comp_reg     <= flyback_pkg::COMP_RST;
      wd_cnt_reg   <= flyback_pkg::CNT_RST;
      fb_prev_reg  <= 1'b0;
    end else begin
      state_reg    <= state_next;
      ss_cnt_reg   <= ss_cnt_next;
      step_cnt_reg <= step_cnt_next;
      comp_reg     <= comp_next;
      wd_cnt_reg   <= wd_cnt_next;
      fb_prev_reg  <= fb_prev_next;
    end
  end

  // secondary supply hysteresis, feedback pulses and short-circuit handling
  always_comb begin
    uv2_next    = uv2_reg;
    ov_next     = ov_reg;
    tx_cnt_next = flyback_pkg::CNT_RST;
    emit_next   = 1'b0;
    sc_next     = sc_reg;
    sc_cnt_next = sc_cnt_reg;
    if (secondary_below_uv_fall) begin
      uv2_next = 1'b1;
    end else if (secondary_above_uv_rise) begin
      uv2_next = 1'b0;
    end
    if (secondary_above_ov_rise) begin
      ov_next = 1'b1;
    end else if (secondary_below_ov_fall) begin
      ov_next = 1'b0;
    end
    if (secondary_above_liveness) begin
      if (tx_cnt_reg >= 32'(flyback_pkg::FB_PULSE_CYC) - 32'h0000_0001) begin
        emit_next = 1'b1;
      end else begin
        tx_cnt_next = tx_cnt_reg + 32'h0000_0001;
      end
    end
    case (sc_reg)
      flyback_pkg::SC_IDLE: begin
        sc_cnt_next = flyback_pkg::CNT_RST;
        if (short_circuit_detect) begin
          sc_next = flyback_pkg::SC_MUTE;
        end
      end
      flyback_pkg::SC_MUTE: begin
        sc_cnt_next = sc_cnt_reg + 32'h0000_0001;
        if (sc_cnt_reg >= 32'(flyback_pkg::MUTE_CYC) - 32'h0000_0001) begin
          sc_next     = flyback_pkg::SC_WAIT;
          sc_cnt_next = flyback_pkg::CNT_RST;
        end
      end
      flyback_pkg::SC_WAIT: begin
        // any high on the emitter restarts the reset-time count
        if (input_emitter) begin
          sc_cnt_next = flyback_pkg::CNT_RST;
        end else if (sc_cnt_reg >= 32'(flyback_pkg::RESET_CYC) - 32'h0000_0001) begin
          sc_next = flyback_pkg::SC_IDLE;
        end else begin
          sc_cnt_next = sc_cnt_reg + 32'h0000_0001;
        end
      end
      default: sc_next = flyback_pkg::SC_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      uv2_reg    <= 1'b1;
      ov_reg     <= 1'b0;
      tx_cnt_reg <= flyback_pkg::CNT_RST;
      emit_reg   <= 1'b0;
      sc_reg     <= flyback_pkg::SC_IDLE;
      sc_cnt_reg <= flyback_pkg::CNT_RST;
    end else begin
      uv2_reg    <= uv2_next;
      ov_reg     <= ov_next;
      tx_cnt_reg <= tx_cnt_next;
      emit_reg   <= emit_next;
      sc_reg     <= sc_next;
      sc_cnt_reg <= sc_cnt_next;
    end
  end

  // flag conditions
  assign supply_fault = primary_supply_low || uv2_reg || ov_reg
                        || (state_reg == flyback_pkg::ST_FB_FAULT);
  assign short_fault  = (sc_reg != flyback_pkg::SC_IDLE)
                        || (state_reg == flyback_pkg::ST_FB_FAULT);

  // output stage
  always_comb begin
    drive_next     = timer_drive && gate_en;
    // the gate output needs no secondary undervoltage and no short fault
    gate_next      = input_emitter && !uv2_reg && (sc_reg == flyback_pkg::SC_IDLE);
    supply_oe_next = supply_fault;
    short_oe_next  = short_fault;
    // decoded from the next state so these flops change together with the state registers
    pull_low_next    = (state_next == flyback_pkg::ST_FB_FAULT);
    gate_oe_next     = (sc_next == flyback_pkg::SC_IDLE);
    shutdown_oe_next = (sc_next != flyback_pkg::SC_IDLE);
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      drive_reg     <= 1'b0;
      gate_reg      <= 1'b0;
      supply_oe_reg <= 1'b1;
      short_oe_reg  <= 1'b0;
      pull_low_reg  <= 1'b0;
      gate_oe_reg   <= 1'b1;
      shutdown_oe_reg <= 1'b0;
    end else begin
      drive_reg     <= drive_next;
      gate_reg      <= gate_next;
      supply_oe_reg <= supply_oe_next;
      short_oe_reg  <= short_oe_next;
      pull_low_reg  <= pull_low_next;
      gate_oe_reg   <= gate_oe_next;
      shutdown_oe_reg <= shutdown_oe_next;
    end
  end

  assign primary_switch_drive   = drive_reg;
  assign comp_level             = comp_reg;
  assign comp_pull_low          = pull_low_reg;
  assign feedback_emitter       = emit_reg;
  assign gate_output            = gate_reg;
  assign gate_output_oe         = gate_oe_reg;
  assign soft_shutdown_output   = 1'b0;
  assign soft_shutdown_oe       = shutdown_oe_reg;
  assign supply_fault_flag_n_o  = 1'b0;
  assign supply_fault_flag_n_oe = supply_oe_reg;
  assign short_fault_flag_n_o   = 1'b0;
  assign short_fault_flag_n_oe  = short_oe_reg;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  ov_cutoff_a: assert property (ov_reg |=> !primary_switch_drive)
    else $error("drive active during overvoltage");
  ov_hold_a: assert property (ov_reg && !secondary_below_ov_fall |=> ov_reg)
    else $error("overvoltage released above fall threshold");
  ov_release_a: assert property (ov_reg && secondary_below_ov_fall && !secondary_above_ov_rise |=> !ov_reg)
    else $error("overvoltage not released below fall threshold");
  trip_off_a: assert property (current_sense_trip |-> ##2 !primary_switch_drive)
    else $error("current trip did not end on-time");
  timeout_go_a: assert property (state_reg == flyback_pkg::ST_SOFT_START
    && ss_cnt_reg == 32'(SOFT_START_CYCLES) - 32'h0000_0001 && !secondary_above_startup
    |=> state_reg == flyback_pkg::ST_TIMEOUT ##1 !primary_switch_drive)
    else $error("start-up timeout not taken");
  timeout_stay_a: assert property (state_reg == flyback_pkg::ST_TIMEOUT |=> state_reg == flyback_pkg::ST_TIMEOUT)
    else $error("left start-up timeout");
  fb_flags_a: assert property (state_reg == flyback_pkg::ST_FB_FAULT |=> supply_fault_flag_n_oe
    && short_fault_flag_n_oe && comp_pull_low && !primary_switch_drive)
    else $error("feedback fault outputs wrong");
  wd_expire_a: assert property (state_reg == flyback_pkg::ST_RUN && !(feedback_pulse_in && !fb_prev_reg)
    && wd_cnt_reg == 32'(FB_TIMEOUT_CYCLES) - 32'h0000_0001 |=> state_reg == flyback_pkg::ST_FB_FAULT)
    else $error("watchdog expiry missed");
  flags_idle_a: assert property (!supply_fault && !short_fault |=> !supply_fault_flag_n_oe && !short_fault_flag_n_oe)
    else $error("flag driven in normal operation");
  sc_mute_a: assert property ($rose(soft_shutdown_oe) |-> soft_shutdown_oe[*8])
    else $error("short fault cleared during mute");
  uv_flag_a: assert property (primary_supply_low && state_reg != flyback_pkg::ST_FB_FAULT
    && sc_reg == flyback_pkg::SC_IDLE |=> supply_fault_flag_n_oe && !short_fault_flag_n_oe)
    else $error("undervoltage flags wrong");

  timeout_c: cover property (state_reg == flyback_pkg::ST_TIMEOUT);
  fb_fault_c: cover property (state_reg == flyback_pkg::ST_FB_FAULT);
  sc_clear_c: cover property (sc_reg == flyback_pkg::SC_WAIT ##1 sc_reg == flyback_pkg::SC_IDLE);
  ov_c: cover property ($fell(ov_reg));

endmodule // flyback_supervisor

// [bench/host_model.sv]
`timescale 1ns/1ps
module host_model (
  // clock and reset
  input  wire logic ref_clk,
  input  wire logic sys_rst,
  // command from the bench
  input  wire logic emitter_cmd,
  // open-drain flag pins
  input  wire logic supply_fault_flag_n_o,
  input  wire logic supply_fault_flag_n_oe,
  input  wire logic short_fault_flag_n_o,
  input  wire logic short_fault_flag_n_oe,
  // host side
  output logic      input_emitter,
  output logic      supply_fault_seen_n,
  output logic      short_fault_seen_n
);
  // pull-up resistors give a high level whenever the pin is released
  assign supply_fault_seen_n = supply_fault_flag_n_oe ? supply_fault_flag_n_o : 1'b1;
  assign short_fault_seen_n  = short_fault_flag_n_oe ? short_fault_flag_n_o : 1'b1;

  // emitter kept dark while the primary side powers up
  always_ff @(posedge ref_clk) begin
    input_emitter <= sys_rst ? 1'b0 : emitter_cmd;
  end
endmodule // host_model

// [bench/flyback_supervisor_status_flags_tb.sv]
`timescale 1ns/1ps
module flyback_supervisor_status_flags_tb;
  // shortened counts keep the run brief
  localparam int unsigned SS_CYC = 2560;
  localparam int unsigned FB_CYC = 200;
  localparam int          LIMIT  = 60000;

  logic        ref_clk, sys_rst, primary_supply_low, secondary_below_uv_fall, secondary_above_uv_rise;
  logic        secondary_above_ov_rise, secondary_below_ov_fall, secondary_above_startup;
  logic        secondary_above_liveness, current_sense_trip, feedback_pulse_in, input_emitter;
  logic        short_circuit_detect, emitter_cmd, fb_en, primary_switch_drive, comp_pull_low;
  logic        feedback_emitter, gate_output, gate_output_oe, soft_shutdown_output, soft_shutdown_oe;
  logic        supply_fault_flag_n_o, supply_fault_flag_n_oe, short_fault_flag_n_o, short_fault_flag_n_oe;
  logic        supply_seen_n, short_seen_n;
  logic [7:0]  comp_level;
  int          fail_count, check_count, cyc, fb_div;

  flyback_supervisor #(.SOFT_START_CYCLES(SS_CYC), .FB_TIMEOUT_CYCLES(FB_CYC)) flyback_supervisor_inst (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .primary_supply_low(primary_supply_low),
    .secondary_below_uv_fall(secondary_below_uv_fall), .secondary_above_uv_rise(secondary_above_uv_rise),
    .secondary_above_ov_rise(secondary_above_ov_rise), .secondary_below_ov_fall(secondary_below_ov_fall),
    .secondary_above_startup(secondary_above_startup), .secondary_above_liveness(secondary_above_liveness),
    .current_sense_trip(current_sense_trip), .feedback_pulse_in(feedback_pulse_in),
    .input_emitter(input_emitter), .short_circuit_detect(short_circuit_detect),
    .primary_switch_drive(primary_switch_drive), .comp_level(comp_level), .comp_pull_low(comp_pull_low),
    .feedback_emitter(feedback_emitter), .gate_output(gate_output), .gate_output_oe(gate_output_oe),
    .soft_shutdown_output(soft_shutdown_output), .soft_shutdown_oe(soft_shutdown_oe),
    .supply_fault_flag_n_o(supply_fault_flag_n_o), .supply_fault_flag_n_oe(supply_fault_flag_n_oe),
    .short_fault_flag_n_o(short_fault_flag_n_o), .short_fault_flag_n_oe(short_fault_flag_n_oe));

  host_model host_model_inst (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .emitter_cmd(emitter_cmd),
    .supply_fault_flag_n_o(supply_fault_flag_n_o), .supply_fault_flag_n_oe(supply_fault_flag_n_oe),
    .short_fault_flag_n_o(short_fault_flag_n_o), .short_fault_flag_n_oe(short_fault_flag_n_oe),
    .input_emitter(input_emitter), .supply_fault_seen_n(supply_seen_n), .short_fault_seen_n(short_seen_n));

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  // secondary side stand-in: one feedback pulse every 100 cycles, well inside the watchdog
  always @(posedge ref_clk) begin
    fb_div <= (fb_div == 99) ? 0 : fb_div + 1;
    feedback_pulse_in <= fb_en && (fb_div == 0);
  end

  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      fail_count++;
      results();
    end
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic wait_rise(output int t);
    int n;
    for (n = 0; n < 1000 && primary_switch_drive !== 1'b0; n++) @(negedge ref_clk);
    for (n = 0; n < 1000 && primary_switch_drive !== 1'b1; n++) @(negedge ref_clk);
    t = cyc;
    check(primary_switch_drive, 1'b1);
  endtask

  // counts cycles in which the primary switch is on
  task automatic watch_drive(input int n, output int highs);
    int i;
    highs = 0;
    for (i = 0; i < n; i++) begin
      @(negedge ref_clk);
      if (primary_switch_drive !== 1'b0) highs++;
    end
  endtask

  task automatic power_up(input logic startup);
    @(posedge ref_clk);
    sys_rst <= 1'b1;
    secondary_above_uv_rise <= 1'b0;
    secondary_below_uv_fall <= 1'b1;
    secondary_above_startup <= startup;
    repeat (3) @(posedge ref_clk);
    sys_rst <= 1'b0;
    @(negedge ref_clk);
    check(primary_switch_drive, 1'b0);
    check(comp_level, 8'h00);
    check(supply_seen_n, 1'b0);
    check(short_seen_n, 1'b1);
    @(posedge ref_clk);
    secondary_above_uv_rise <= 1'b1;
    secondary_below_uv_fall <= 1'b0;
    repeat (4) @(negedge ref_clk);
    check(supply_seen_n, 1'b1);
    check(short_seen_n, 1'b1);
    repeat (SS_CYC / 2 - 5) @(negedge ref_clk);
    check(comp_level > 8'h70 && comp_level < 8'h90, 1'b1);
    repeat (SS_CYC / 2 + 20) @(negedge ref_clk);
  endtask

  task automatic t_switching();
    int i, t0, t1, p, last;
    last = 0;
    wait_rise(t0);
    for (i = 0; i < 4; i++) begin
      wait_rise(t1);
      p = t1 - t0;
      check(p >= flyback_pkg::SW_PERIOD_CYC - flyback_pkg::DITHER_CYC
            && p <= flyback_pkg::SW_PERIOD_CYC + flyback_pkg::DITHER_CYC, 1'b1);
      if (i > 0) check(p != last, 1'b1);
      last = p;
      t0 = t1;
    end
  endtask

  task automatic t_current_trip();
    int t;
    wait_rise(t);
    @(posedge ref_clk);
    current_sense_trip <= 1'b1;
    repeat (2) @(posedge ref_clk);
    @(negedge ref_clk);
    check(primary_switch_drive, 1'b0);
    @(posedge ref_clk);
    current_sense_trip <= 1'b0;
    wait_rise(t);
  endtask

  task automatic t_overvoltage();
    int h, t;
    @(posedge ref_clk);
    emitter_cmd <= 1'b1;
    secondary_above_ov_rise <= 1'b1;
    secondary_below_ov_fall <= 1'b0;
    repeat (3) @(negedge ref_clk);
    check(supply_seen_n, 1'b0);
    check(short_seen_n, 1'b1);
    check(gate_output_oe, 1'b1);
    check(gate_output, 1'b1);
    watch_drive(800, h);
    check(h == 0, 1'b1);
    @(posedge ref_clk);
    secondary_above_ov_rise <= 1'b0;
    watch_drive(800, h);
    check(h == 0, 1'b1);
    check(supply_seen_n, 1'b0);
    @(posedge ref_clk);
    secondary_below_ov_fall <= 1'b1;
    repeat (3) @(negedge ref_clk);
    check(supply_seen_n, 1'b1);
    @(posedge ref_clk);
    primary_supply_low <= 1'b1;
    repeat (3) @(negedge ref_clk);
    check({supply_seen_n, short_seen_n}, 2'b01);
    @(posedge ref_clk);
    primary_supply_low <= 1'b0;
    secondary_below_uv_fall <= 1'b1;
    secondary_above_uv_rise <= 1'b0;
    repeat (3) @(negedge ref_clk);
    check({supply_seen_n, short_seen_n, gate_output}, 3'b010);
    @(posedge ref_clk);
    secondary_below_uv_fall <= 1'b0;
    secondary_above_uv_rise <= 1'b1;
    repeat (3) @(negedge ref_clk);
    check({supply_seen_n, gate_output}, 2'b11);
    wait_rise(t);
  endtask

  task automatic t_short();
    @(posedge ref_clk);
    short_circuit_detect <= 1'b1;
    repeat (3) @(negedge ref_clk);
    check(short_seen_n, 1'b0);
    check(supply_seen_n, 1'b1);
    check({soft_shutdown_oe, soft_shutdown_output, gate_output_oe}, 3'b100);
    @(posedge ref_clk);
    short_circuit_detect <= 1'b0;
    primary_supply_low <= 1'b1;
    repeat (3) @(negedge ref_clk);
    check({supply_seen_n, short_seen_n}, 2'b00);
    @(posedge ref_clk);
    primary_supply_low <= 1'b0;
    repeat (200) @(negedge ref_clk);
    check({supply_seen_n, short_seen_n}, 2'b10);
    @(posedge ref_clk);
    emitter_cmd <= 1'b0;
    repeat (40) @(negedge ref_clk);
    check(short_seen_n, 1'b0);
    repeat (20) @(negedge ref_clk);
    check(short_seen_n, 1'b1);
    check({soft_shutdown_oe, gate_output_oe}, 2'b01);
  endtask

  task automatic t_liveness();
    int i, n;
    for (int k = 0; k < 2; k++) begin
      @(posedge ref_clk);
      secondary_above_liveness <= (k == 0);
      n = 0;
      // a pulse already launched from the old level must not be counted
      @(posedge ref_clk);
      for (i = 0; i < 2100; i++) begin
        @(negedge ref_clk);
        if (feedback_emitter !== 1'b0) n++;
      end
      if (k == 0) check(n >= 2 && n <= 3, 1'b1);
      else check(n == 0, 1'b1);
    end
  endtask

  task automatic t_fb_fault();
    int h;
    @(posedge ref_clk);
    fb_en <= 1'b0;
    repeat (FB_CYC - 110) @(negedge ref_clk);
    check(supply_seen_n, 1'b1);
    repeat (130) @(negedge ref_clk);
    check({supply_seen_n, short_seen_n}, 2'b00);
    check({comp_pull_low, primary_switch_drive}, 2'b10);
    check(comp_level, 8'h00);
    @(posedge ref_clk);
    fb_en <= 1'b1;
    watch_drive(1500, h);
    check(h == 0, 1'b1);
    check({supply_seen_n, short_seen_n}, 2'b00);
  endtask

  task automatic t_startup_timeout();
    int h, t;
    power_up(1'b0);
    watch_drive(2000, h);
    check(h == 0, 1'b1);
    @(posedge ref_clk);
    secondary_above_startup <= 1'b1;
    watch_drive(2000, h);
    check(h == 0, 1'b1);
    power_up(1'b1);
    wait_rise(t);
  endtask

  initial begin
    fail_count = 0;
    check_count = 0;
    cyc = 0;
    fb_div = 0;
    fb_en = 1'b1;
    sys_rst = 1'b1;
    primary_supply_low = 1'b0;
    secondary_below_uv_fall = 1'b1;
    secondary_above_uv_rise = 1'b0;
    secondary_above_ov_rise = 1'b0;
    secondary_below_ov_fall = 1'b1;
    secondary_above_startup = 1'b1;
    secondary_above_liveness = 1'b1;
    current_sense_trip = 1'b0;
    short_circuit_detect = 1'b0;
    emitter_cmd = 1'b0;
    power_up(1'b1);
    t_switching();
    t_current_trip();
    t_overvoltage();
    t_short();
    t_liveness();
    t_fb_fault();
    t_startup_timeout();
    results();
  end
endmodule // flyback_supervisor_status_flags_tb
